//--- srs_divider.sv
// Clock-enable divider producing rise and fall phase pulses
`timescale 1ns/1ps
module srs_divider
	import srs_pkg::*;
#(
	parameter int DIV = 4
)
(
	input wire logic mclk, // master clock
	input wire logic reset_n, // async reset, active low
	input wire logic hold, // stop and rephase the divider
	output srs_tick_t tick // phase pulses, one mclk cycle each
);

	localparam logic [DIV_W-1:0] LAST = DIV_W'(DIV - 1);
	localparam logic [DIV_W-1:0] HALF = DIV_W'(DIV / 2);
	localparam logic [DIV_W-1:0] ZERO = 6'h00;
	localparam logic [DIV_W-1:0] ONE = 6'h01;

	logic [DIV_W-1:0] phase_q;

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			phase_q <= ZERO;
		else if (hold || phase_q == LAST)
			phase_q <= ZERO;
		else
			phase_q <= phase_q + ONE;
	end

	// Registered so the pulses leave straight from flops
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			tick <= '0;
		else
		begin
			tick.rise <= !hold && phase_q == ZERO;
			tick.fall <= !hold && phase_q == HALF;
		end
	end

endmodule // srs_divider

//--- srs_downstream_model.sv
// Downstream logic model that times each staged release it sees
`timescale 1ns/1ps
module srs_downstream_model
	import srs_pkg::*;
(
	input wire logic mclk, // master clock
	input wire srs_stage_t stage, // staged resets, active low
	input wire logic combined, // combined reset, active high
	input wire logic wdResetN, // watchdog logic reset, active low
	input wire logic oscEn, // oscillator enable pulse
	input wire logic sysEn, // system enable pulse
	output int wdCnt, // osc ticks before watchdog logic release
	output int oscCnt, // osc ticks before clock generator release
	output int periCnt, // sys ticks before peripheral release
	output int coreCnt, // sys ticks before core release
	output int earlySys // sys ticks while clock generator held
);
	// Counts clear on every combined reset, so a restart shows as a full count
	always @(posedge mclk)
	begin
		if (combined !== 1'b0)
		begin
			wdCnt <= 0;
			oscCnt <= 0;
			periCnt <= 0;
			coreCnt <= 0;
			earlySys <= 0;
		end
		else
		begin
			if (oscEn === 1'b1 && wdResetN === 1'b0)
				wdCnt <= wdCnt + 1;
			if (oscEn === 1'b1 && stage.clkGenN === 1'b0)
				oscCnt <= oscCnt + 1;
			if (sysEn === 1'b1 && stage.clkGenN === 1'b0)
				earlySys <= earlySys + 1;
			if (sysEn === 1'b1 && stage.clkGenN === 1'b1 && stage.periphN === 1'b0)
				periCnt <= periCnt + 1;
			if (sysEn === 1'b1 && stage.periphN === 1'b1 && stage.coreN === 1'b0)
				coreCnt <= coreCnt + 1;
		end
	end
endmodule // srs_downstream_model

//--- srs_pkg.sv
// Constants and carrier types shared by the reset sequencer files
package srs_pkg;

	// Master clock rate in MHz; slower rates are enable pulses derived from it
	localparam int MCLK_MHZ = 250;

	// Divider ratios (mclk cycles per derived cycle) and divider phase counter width
	localparam int OSC_DIV = 32;
	localparam int SYS_DIV = 12;
	localparam int SYS3X_DIV = 4;
	localparam int DIV_W = 6;

	// Stretcher counter width and stage lengths in derived-clock cycles
	localparam int CNT_W = 7;
	localparam logic [CNT_W-1:0] POR_STRETCH = 7'h40;
	localparam logic [CNT_W-1:0] SYNC_GEN_STRETCH = 7'h03;
	localparam logic [CNT_W-1:0] CLKGEN_STRETCH = 7'h20;
	localparam logic [CNT_W-1:0] PERIPH_STRETCH = 7'h20;
	localparam logic [CNT_W-1:0] CORE_STRETCH = 7'h20;
	localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;
	localparam logic [CNT_W-1:0] CNT_MAX = 7'h7F;

	// Rising and falling phase enables of one derived clock
	typedef struct packed {
		logic rise;
		logic fall;
	} srs_tick_t;

	// Staged reset outputs, all active low
	typedef struct packed {
		logic clkGenN;
		logic periphN;
		logic coreN;
	} srs_stage_t;

endpackage

//--- srs_sequencer.sv
// Reset gathering, stretching and staged release for the integration unit
//
// Contract
// - Five sources: pin, power-on, software, watchdog twice
// - Power-on reset stretched 64 oscillator cycles
// - Combined reset ORs sources, holds later stages
// - Control, sync generator, clkgen stretch follow combined
// - Watchdog/software logic held three oscillator cycles
// - Clock-generator reset released after 32 oscillator cycles
// - Early delay counters use oscillator time base
// - Clock-generator reset released on oscillator falling phase
// - Clock generation starts after clock-generator release
// - Peripheral reset released 32 system cycles later
// - Core reset released 32 system cycles after peripheral
// - Peripheral and core release on system falling phase
// - Core release starts code, ends start-up
// - Test port reset from power-on only
// - Common system rate, optional triple rate timers
// - No interrupts raised by this unit
`timescale 1ns/1ps
module srs_sequencer
	import srs_pkg::*;
(
	input wire logic mclk, // master clock, 250 MHz
	input wire logic reset_n, // async reset, active low
	input wire logic extResetPinN, // external reset pin, active low, async
	input wire logic powerOnN, // raw power-on detector, active low, async
	input wire logic swResetReq, // control register software reset write, pulse
	input wire logic watchdogTimeout, // watchdog time-out reset, level
	input wire logic watchdogLostRef, // watchdog loss-of-reference reset, level
	input wire logic fastTimerSel, // timers and modulator at triple rate
	output srs_stage_t stageReset_q, // staged resets, active low
	output logic watchdogLogicResetN_q, // watchdog/software logic reset, active low
	output logic testPortResetN_q, // test-port reset, active low
	output logic combinedReset_q, // combined reset, active high
	output logic startupDone_q, // core running, start-up complete
	output logic oscClkEn, // oscillator clock enable pulse
	output logic sysClkEn, // system clock enable pulse
	output logic timerClkEn_q // quad timer and modulator clock enable pulse
);

	// Pin synchronisers; first stages read by the second only
	logic extPinMeta_q;
	logic extPinSync_q;
	logic porMeta_q;
	logic porSync_q;

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			extPinMeta_q <= 1'b0;
			extPinSync_q <= 1'b0;
		end
		else
		begin
			extPinMeta_q <= extResetPinN;
			extPinSync_q <= extPinMeta_q;
		end
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			porMeta_q <= 1'b0;
			porSync_q <= 1'b0;
		end
		else
		begin
			porMeta_q <= powerOnN;
			porSync_q <= porMeta_q;
		end
	end

	logic porActive;
	logic extPinActive;
	assign porActive = !porSync_q;
	assign extPinActive = !extPinSync_q;

	// Derived clock phases
	srs_tick_t oscTick;
	srs_tick_t sysTick;
	srs_tick_t sys3xTick;
	logic clkGenReleased;
	logic periphReleased;
	logic coreReleased;
	logic porReleased;
	logic wdLogicReleased;

	// Oscillator runs free; it is the only time base during early reset
	srs_divider #(.DIV(OSC_DIV)) u_osc_div (
		.mclk(mclk),
		.reset_n(reset_n),
		.hold(1'b0),
		.tick(oscTick)
	);

	// System clocks only run once the clock generator is out of reset
	srs_divider #(.DIV(SYS_DIV)) u_sys_div (
		.mclk(mclk),
		.reset_n(reset_n),
		.hold(!clkGenReleased),
		.tick(sysTick)
	);

	srs_divider #(.DIV(SYS3X_DIV)) u_sys3x_div (
		.mclk(mclk),
		.reset_n(reset_n),
		.hold(!clkGenReleased),
		.tick(sys3xTick)
	);

	assign oscClkEn = oscTick.rise;
	assign sysClkEn = sysTick.rise;

	// One common rate everywhere except the optional triple-rate timers
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			timerClkEn_q <= 1'b0;
		else
			timerClkEn_q <= fastTimerSel ? sys3xTick.rise : sysTick.rise;
	end

	// Power-on extender: the only stage not held by the combined reset
	srs_stretcher #(.COUNT(POR_STRETCH)) u_por_ext (
		.mclk(mclk),
		.reset_n(reset_n),
		.hold(porActive),
		.countTick(oscTick.rise),
		.releaseTick(oscTick.rise),
		.released(porReleased)
	);

	// Software request is caught between system edges, then applied on one
	logic swPending_q;
	logic swReset_q;
	logic wdReset_q;

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			swPending_q <= 1'b0;
		else if (!wdLogicReleased)
			swPending_q <= 1'b0;
		else if (swResetReq)
			swPending_q <= 1'b1;
		else if (sysTick.rise)
			swPending_q <= 1'b0;
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			swReset_q <= 1'b0;
		else if (!wdLogicReleased)
			swReset_q <= 1'b0;
		else if (swPending_q && sysTick.rise)
			swReset_q <= 1'b1;
	end

	// Watchdog reset latched so a short request still runs the full sequence
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			wdReset_q <= 1'b0;
		else if (!wdLogicReleased)
			wdReset_q <= 1'b0;
		else if (watchdogTimeout || watchdogLostRef)
			wdReset_q <= 1'b1;
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			combinedReset_q <= 1'b1;
		else
			combinedReset_q <= !porReleased || extPinActive || wdReset_q || swReset_q;
	end

	// Synchronous reset generator for watchdog and software reset logic
	srs_stretcher #(.COUNT(SYNC_GEN_STRETCH)) u_sync_gen (
		.mclk(mclk),
		.reset_n(reset_n),
		.hold(combinedReset_q),
		.countTick(oscTick.rise),
		.releaseTick(oscTick.rise),
		.released(wdLogicReleased)
	);

	// Clock-generator extender, released on the oscillator falling phase
	srs_stretcher #(.COUNT(CLKGEN_STRETCH)) u_clkgen_ext (
		.mclk(mclk),
		.reset_n(reset_n),
		.hold(combinedReset_q),
		.countTick(oscTick.rise),
		.releaseTick(oscTick.fall),
		.released(clkGenReleased)
	);

	// Falling phase of the system clock stands in for the delayed system clock
	srs_stretcher #(.COUNT(PERIPH_STRETCH)) u_periph_ext (
		.mclk(mclk),
		.reset_n(reset_n),
		.hold(!clkGenReleased),
		.countTick(sysTick.rise),
		.releaseTick(sysTick.fall),
		.released(periphReleased)
	);

	srs_stretcher #(.COUNT(CORE_STRETCH)) u_core_ext (
		.mclk(mclk),
		.reset_n(reset_n),
		.hold(!periphReleased),
		.countTick(sysTick.rise),
		.releaseTick(sysTick.fall),
		.released(coreReleased)
	);

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			stageReset_q <= '0;
			watchdogLogicResetN_q <= 1'b0;
		end
		else
		begin
			stageReset_q.clkGenN <= clkGenReleased;
			stageReset_q.periphN <= periphReleased;
			stageReset_q.coreN <= coreReleased;
			watchdogLogicResetN_q <= wdLogicReleased;
		end
	end

	// Status is a level only; no interrupt request leaves this unit
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			startupDone_q <= 1'b0;
		else
			startupDone_q <= coreReleased;
	end

	// Debug access must survive pin, software and watchdog resets
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			testPortResetN_q <= 1'b0;
		else
			testPortResetN_q <= porReleased;
	end

	// Helper: oscillator ticks since combined reset cleared
	logic [CNT_W-1:0] oscSeen_q;

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			oscSeen_q <= CNT_ZERO;
		else if (combinedReset_q)
			oscSeen_q <= CNT_ZERO;
		else if (oscTick.rise && oscSeen_q != CNT_MAX)
			oscSeen_q <= oscSeen_q + CNT_ONE;
	end

	chk_combined_holds: assert property (@(posedge mclk) disable iff (!reset_n)
		combinedReset_q |-> ##2 !stageReset_q.clkGenN)
		else $error("clock-generator reset not held by combined reset");

	chk_clkgen_count: assert property (@(posedge mclk) disable iff (!reset_n)
		$rose(stageReset_q.clkGenN) |-> oscSeen_q == CLKGEN_STRETCH)
		else $error("clock-generator reset released after wrong count");

	chk_clkgen_phase: assert property (@(posedge mclk) disable iff (!reset_n)
		$rose(stageReset_q.clkGenN) |-> $past(oscTick.fall, 2))
		else $error("clock-generator reset not released on falling phase");

	chk_periph_order: assert property (@(posedge mclk) disable iff (!reset_n)
		!stageReset_q.clkGenN |=> !stageReset_q.periphN)
		else $error("peripheral reset out while clock generator in reset");

	chk_core_order: assert property (@(posedge mclk) disable iff (!reset_n)
		!stageReset_q.periphN |=> !stageReset_q.coreN)
		else $error("core reset out while peripherals in reset");

	chk_stage_phase: assert property (@(posedge mclk) disable iff (!reset_n)
		($rose(stageReset_q.periphN) || $rose(stageReset_q.coreN)) |-> $past(sysTick.fall, 2))
		else $error("stage reset not released on system falling phase");

	chk_test_por_only: assert property (@(posedge mclk) disable iff (!reset_n)
		$fell(testPortResetN_q) |-> $past(porActive, 2))
		else $error("test-port reset asserted without power-on reset");

	chk_sw_reset_sync: assert property (@(posedge mclk) disable iff (!reset_n)
		$rose(swReset_q) |-> $past(sysTick.rise) ##1 combinedReset_q)
		else $error("software reset not aligned to system clock");

	// Release waits for the rise after the third, so three full periods pass
	chk_sync_gen_hold: assert property (@(posedge mclk) disable iff (!reset_n)
		$rose(watchdogLogicResetN_q) |-> oscSeen_q == SYNC_GEN_STRETCH + CNT_ONE)
		else $error("watchdog logic released after wrong count");

endmodule // srs_sequencer

//--- srs_stretcher.sv
// One reset stretch stage: counts ticks after its hold clears
`timescale 1ns/1ps
module srs_stretcher
	import srs_pkg::*;
#(
	parameter logic [CNT_W-1:0] COUNT = CNT_ONE
)
(
	input wire logic mclk, // master clock
	input wire logic reset_n, // async reset, active low
	input wire logic hold, // upstream reset still active
	input wire logic countTick, // time base enable
	input wire logic releaseTick, // phase on which release may occur
	output logic released // stage out of reset
);

	logic [CNT_W-1:0] count_q;

	// Any reassertion restarts the count from zero
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			count_q <= CNT_ZERO;
		else if (hold)
			count_q <= CNT_ZERO;
		else if (countTick && count_q < COUNT)
			count_q <= count_q + CNT_ONE;
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			released <= 1'b0;
		else if (hold)
			released <= 1'b0;
		else if (count_q == COUNT && releaseTick)
			released <= 1'b1;
	end

endmodule // srs_stretcher

//--- testbench.sv
// Self-checking bench for the staged reset sequencer
`timescale 1ns/1ps
module testbench;
	import srs_pkg::*;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic extResetPinN = 1'b1;
	logic powerOnN = 1'b0;
	logic swResetReq = 1'b0;
	logic watchdogTimeout = 1'b0;
	logic watchdogLostRef = 1'b0;
	logic fastTimerSel = 1'b0;
	srs_stage_t stageReset_q;
	logic watchdogLogicResetN_q, testPortResetN_q, combinedReset_q, startupDone_q;
	logic oscClkEn, sysClkEn, timerClkEn_q;
	int wdCnt, oscCnt, periCnt, coreCnt, earlySys;
	int num_errors = 0;
	int checked = 0;
	int cycles = 0;
	int seed = 76454;
	int n;

	always #2 mclk = ~mclk;

	srs_sequencer i_dut (.mclk(mclk), .reset_n(reset_n), .extResetPinN(extResetPinN),
		.powerOnN(powerOnN), .swResetReq(swResetReq), .watchdogTimeout(watchdogTimeout),
		.watchdogLostRef(watchdogLostRef), .fastTimerSel(fastTimerSel),
		.stageReset_q(stageReset_q), .watchdogLogicResetN_q(watchdogLogicResetN_q),
		.testPortResetN_q(testPortResetN_q), .combinedReset_q(combinedReset_q),
		.startupDone_q(startupDone_q), .oscClkEn(oscClkEn), .sysClkEn(sysClkEn),
		.timerClkEn_q(timerClkEn_q));

	srs_downstream_model i_model (.mclk(mclk), .stage(stageReset_q),
		.combined(combinedReset_q), .wdResetN(watchdogLogicResetN_q), .oscEn(oscClkEn),
		.sysEn(sysClkEn), .wdCnt(wdCnt), .oscCnt(oscCnt), .periCnt(periCnt),
		.coreCnt(coreCnt), .earlySys(earlySys));

	task test_done();
		$display("checked %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task chk_rng(input int v, input int lo, input int hi);
		checked++;
		if (v < lo || v > hi)
		begin
			num_errors++;
			$display("wrong value at %0t: %h expected %h", $time, v, lo);
		end
	endtask

	task chk_bits(input logic [3:0] v, input logic [3:0] e);
		checked++;
		if (v !== e)
		begin
			num_errors++;
			$display("wrong value at %0t: %h expected %h", $time, v, e);
		end
	endtask

	// Bounded wait for a design output to reach a level
	task wait_for(input int which, input logic lvl);
		n = 0;
		while (n < 9000 && (which == 0 ? combinedReset_q : which == 1 ? startupDone_q
			: stageReset_q.clkGenN) !== lvl)
		begin
			@(posedge mclk);
			n++;
		end
		chk_rng(n, 0, 8999);
	endtask

	// Full release after any source: ordered stages with the stated counts
	task chk_release();
		wait_for(1, 1'b1);
		@(posedge mclk);
		chk_rng(wdCnt, 3, 4);
		chk_rng(oscCnt, 32, 33);
		chk_rng(earlySys, 0, 0);
		chk_rng(periCnt, 32, 33);
		chk_rng(coreCnt, 32, 33);
		chk_bits({stageReset_q, startupDone_q}, 4'hF);
	endtask

	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			num_errors++;
			test_done();
		end
	end

	initial
	begin
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (20) @(posedge mclk);
		chk_bits({stageReset_q, testPortResetN_q}, 4'h0);
		powerOnN <= 1'b1;
		n = 0;
		while (combinedReset_q !== 1'b0 && n < 3000)
		begin
			@(posedge mclk);
			if (oscClkEn === 1'b1)
				n++;
		end
		chk_rng(n, 64, 65);
		chk_release();
		chk_bits({3'h0, testPortResetN_q}, 4'h1);
		// Pin, software and both watchdog sources, each followed by the whole sequence again
		for (int k = 0; k < 4; k++)
		begin
			repeat (5 + ($unsigned($random(seed)) % 40)) @(posedge mclk);
			fastTimerSel <= ($random(seed) % 2) != 0;
			case (k)
				0: extResetPinN <= 1'b0;
				1: swResetReq <= 1'b1;
				2: watchdogTimeout <= 1'b1;
				default: watchdogLostRef <= 1'b1;
			endcase
			repeat (k == 0 ? 4 + ($unsigned($random(seed)) % 20) : 1) @(posedge mclk);
			extResetPinN <= 1'b1;
			swResetReq <= 1'b0;
			watchdogTimeout <= 1'b0;
			watchdogLostRef <= 1'b0;
			wait_for(0, 1'b1);
			repeat (4) @(posedge mclk);
			chk_bits({stageReset_q, testPortResetN_q}, 4'h1);
			chk_release();
		end
		// Reassertion while the peripheral stage is counting
		extResetPinN <= 1'b0;
		repeat (10) @(posedge mclk);
		extResetPinN <= 1'b1;
		wait_for(2, 1'b1);
		repeat (100 + ($unsigned($random(seed)) % 200)) @(posedge mclk);
		extResetPinN <= 1'b0;
		repeat (6) @(posedge mclk);
		chk_bits({stageReset_q, startupDone_q}, 4'h0);
		extResetPinN <= 1'b1;
		chk_release();
		// Power-on again: test port drops as well, then the whole sequence
		powerOnN <= 1'b0;
		repeat (10) @(posedge mclk);
		chk_bits({stageReset_q, testPortResetN_q}, 4'h0);
		powerOnN <= 1'b1;
		chk_release();
		chk_bits({3'h0, testPortResetN_q}, 4'h1);
		// Timer enable rate, triple and plain
		for (int f = 1; f >= 0; f--)
		begin
			fastTimerSel <= f[0];
			repeat (30) @(posedge mclk);
			n = 0;
			repeat (96)
			begin
				@(posedge mclk);
				if (timerClkEn_q === 1'b1)
					n++;
			end
			chk_rng(n, f ? 24 : 8, f ? 24 : 8);
		end
		test_done();
	end
endmodule // testbench
